// ### port_expander_regs.svh
`ifndef PORT_EXPANDER_REGS_SVH
`define PORT_EXPANDER_REGS_SVH

// Slave address upper bits for the two address groups
`define HI_GROUP_PREFIX 3'h5
`define LO_GROUP_PREFIX 3'h6
// Push-pull outputs reached at the high group address
`define HI_OUT_LSB 4
`define HI_OUT_MSB 11
// Bit positions inside the low-group data byte
`define LO_PP_LSB_A 0
`define LO_PP_MSB_A 1
`define LO_OD_LSB 2
`define LO_OD_MSB 5
`define LO_PP_LSB_B 6
`define LO_PP_MSB_B 7
// Push-pull output bits held in the low-group byte
`define LO_OUT_MSB_A 1
`define LO_OUT_LSB_B 2
`define LO_OUT_MSB_B 3
// Open-drain port pairs
`define OD_PAIR_A_LSB 0
`define OD_PAIR_A_MSB 1
`define OD_PAIR_B_LSB 2
`define OD_PAIR_B_MSB 3
// I2C address phase length and index of the last bit in a byte
`define ADDR_BITS 7
`define BYTE_LAST 3'h7

`endif

// ### port_expander_pkg.sv
package port_expander_pkg;

  // Serial engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WDATA,
    ST_WACK,
    ST_RDATA,
    ST_RACK,
    ST_IGNORE
  } serial_state_t;

  // Bus line levels passed together
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_t;

  // Strap selection caught at power-up
  typedef struct packed {
    logic pair_b;
    logic pair_a;
  } strap_sel_t;

endpackage : port_expander_pkg

// ### i2c_port_expander_core.sv
`timescale 1ns/100ps
`include "port_expander_regs.svh"

module i2c_port_expander_core
  import port_expander_pkg::*;
#(
  parameter int PP_COUNT = 12,
  parameter int OD_COUNT = 4
)
(
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic                scl_clk,
  input  wire logic                sda_in,
  output logic                     sda_oe_n,
  output logic                     sda_out,
  input  wire logic                bus_abort_n,
  input  wire logic                strap_pin_a,
  input  wire logic                strap_pin_b,
  input  wire logic [OD_COUNT-1:0] od_pin_in,
  output logic [OD_COUNT-1:0]      open_drain_io_ports,
  output logic [OD_COUNT-1:0]      od_pullup_en,
  output logic [PP_COUNT-1:0]      push_pull_outputs,
  output logic [OD_COUNT-1:0]      change_flags,
  output logic                     alert_oe_n,
  output logic                     standby
);

  initial
  begin
    if (PP_COUNT != 12 || OD_COUNT != 4)
      $error("port expander serves twelve push-pull and four open-drain ports only");
  end

  // Fans one strap bit out over a pair of latch bits
  function automatic logic [1:0] pair_of(input logic sel);
    pair_of = {sel, sel};
  endfunction : pair_of

  // ---------------- link domain (scl_clk) ----------------
  // SDA is sampled on SCL rise; START/STOP seen on SDA edges while SCL high.
  logic          start_tgl_q;
  logic          stop_tgl_q;
  logic          start_seen;
  logic          sda_fall_q;

  // START: SDA falls while SCL high; toggles an event flag
  always_ff @(negedge sda_in or posedge reset)
  begin
    if (reset)
      start_tgl_q <= 1'b0;
    else if (scl_clk)
      start_tgl_q <= ~start_tgl_q;
  end

  // STOP: SDA rises while SCL high
  always_ff @(posedge sda_in or posedge reset)
  begin
    if (reset)
      stop_tgl_q <= 1'b0;
    else if (scl_clk)
      stop_tgl_q <= ~stop_tgl_q;
  end

  // Bit engine state in the link domain
  serial_state_t state_q,  state_d;
  logic [2:0]    bitcnt_q, bitcnt_d;
  logic [7:0]    shift_q,  shift_d;
  logic          hi_grp_q, hi_grp_d;
  logic          rd_q,     rd_d;
  logic          start_ack_q;
  logic          wr_tgl_q, wr_tgl_d;
  logic [7:0]    wdata_q,  wdata_d;
  logic          acc_tgl_q, acc_tgl_d;
  logic [7:0]    rdata_q,  rdata_d;
  logic [7:0]    rd_byte;
  logic [OD_COUNT-1:0] od_cross_q, od_link_q;
  logic [3:0]    lo_pp_link_q;
  logic [7:0]    hi_pp_link_q;
  logic          abort_s1_q, abort_s2_q;
  logic          stop_ack_q;
  logic [PP_COUNT-1:0] pp_cross_q;

  assign start_seen = start_ack_q != start_tgl_q;

  // Read byte: sensed pin levels for open-drain ports
  always_comb
  begin
    if (hi_grp_q)
      rd_byte = hi_pp_link_q;
    else
      rd_byte = {lo_pp_link_q[`LO_OUT_MSB_B:`LO_OUT_LSB_B], od_link_q,
                 lo_pp_link_q[`LO_OUT_MSB_A:0]};
  end

  // Next-state logic of the serial engine
  always_comb
  begin
    state_d   = state_q;
    bitcnt_d  = bitcnt_q;
    shift_d   = {shift_q[6:0], sda_in};
    hi_grp_d  = hi_grp_q;
    rd_d      = rd_q;
    wr_tgl_d  = wr_tgl_q;
    wdata_d   = wdata_q;
    acc_tgl_d = acc_tgl_q;
    rdata_d   = rdata_q;
    if (start_seen)
    begin
      state_d  = ST_ADDR;
      bitcnt_d = 3'h1;
      shift_d  = {7'h00, sda_in};
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          state_d = ST_IDLE;
        ST_ADDR:
        begin
          bitcnt_d = bitcnt_q + 3'h1;
          if (bitcnt_q == `BYTE_LAST)
          begin
            // Address match on either group prefix
            if (shift_q[6:4] == `HI_GROUP_PREFIX || shift_q[6:4] == `LO_GROUP_PREFIX)
            begin
              hi_grp_d  = shift_q[6:4] == `HI_GROUP_PREFIX;
              rd_d      = sda_in;
              acc_tgl_d = ~acc_tgl_q;
              state_d   = ST_ADDR_ACK;
            end
            else
              state_d = ST_IGNORE;
          end
        end
        ST_ADDR_ACK:
        begin
          bitcnt_d = 3'h0;
          rdata_d  = rd_byte;
          state_d  = rd_q ? ST_RDATA : ST_WDATA;
        end
        ST_WDATA:
        begin
          bitcnt_d = bitcnt_q + 3'h1;
          if (bitcnt_q == `BYTE_LAST)
          begin
            wdata_d  = {shift_q[6:0], sda_in};
            wr_tgl_d = ~wr_tgl_q;
            state_d  = ST_WACK;
          end
        end
        ST_WACK:
        begin
          bitcnt_d = 3'h0;
          state_d  = ST_WDATA;
        end
        ST_RDATA:
        begin
          bitcnt_d = bitcnt_q + 3'h1;
          rdata_d  = {rdata_q[6:0], 1'b1};
          if (bitcnt_q == `BYTE_LAST)
            state_d = ST_RACK;
        end
        ST_RACK:
        begin
          bitcnt_d = 3'h0;
          rdata_d  = rd_byte;
          state_d  = sda_in ? ST_IGNORE : ST_RDATA;
        end
        ST_IGNORE:
          state_d = ST_IGNORE;
        default:
          state_d = ST_IDLE;
      endcase
    end
  end

  // Link registers; abort or power-on reset idles the engine
  always_ff @(posedge scl_clk)
  begin
    abort_s1_q <= ~bus_abort_n;
    abort_s2_q <= abort_s1_q;
    od_cross_q <= od_pin_in;
    od_link_q  <= od_cross_q;
    // Output latches cross into the link domain for read-back
    pp_cross_q   <= push_pull_outputs;
    lo_pp_link_q <= pp_cross_q[`LO_OUT_MSB_B:0];
    hi_pp_link_q <= pp_cross_q[`HI_OUT_MSB:`HI_OUT_LSB];
    stop_ack_q   <= stop_tgl_q;
    if (reset || abort_s2_q)
    begin
      state_q     <= ST_IDLE;
      bitcnt_q    <= 3'h0;
      shift_q     <= 8'h00;
      hi_grp_q    <= 1'b0;
      rd_q        <= 1'b0;
      start_ack_q <= start_tgl_q;
      rdata_q     <= 8'hff;
    end
    else
    begin
      state_q     <= state_d;
      bitcnt_q    <= bitcnt_d;
      shift_q     <= shift_d;
      hi_grp_q    <= hi_grp_d;
      rd_q        <= rd_d;
      start_ack_q <= start_tgl_q;
      rdata_q     <= rdata_d;
    end
    if (reset)
    begin
      wr_tgl_q  <= 1'b0;
      wdata_q   <= 8'h00;
      acc_tgl_q <= 1'b0;
    end
    else
    begin
      wr_tgl_q  <= wr_tgl_d;
      wdata_q   <= wdata_d;
      acc_tgl_q <= acc_tgl_d;
    end
  end

  // ACK and read data drive SDA low on SCL fall
  always_ff @(negedge scl_clk)
  begin
    if (reset)
    begin
      sda_oe_n <= 1'b1;
      sda_out  <= 1'b0;
    end
    else
    begin
      sda_out  <= 1'b0;
      sda_oe_n <= !(state_q == ST_ADDR_ACK || state_q == ST_WACK ||
                    (state_q == ST_RDATA && !rdata_q[7]));
    end
  end

  // ---------------- core domain (core_clk) ----------------
  logic [2:0]          wr_sync_q;
  logic [2:0]          acc_sync_q;
  logic [7:0]          wdata_core_q;
  logic                hi_grp_core;
  logic [OD_COUNT-1:0] pin_s1_q, pin_s2_q, ref_q, ref_d, flag_d;
  logic [1:0]          strap_s1_q, strap_s2_q;
  strap_sel_t          strap_q;
  logic                strap_taken_q;
  logic [PP_COUNT-1:0] pp_d;
  logic [OD_COUNT-1:0] od_d;
  logic                alert_d;
  logic                idle_s1_q;

  assign hi_grp_core = hi_grp_q;

  // Strap and pin synchronisers, event toggle crossings
  always_ff @(posedge core_clk)
  begin
    strap_s1_q <= {strap_pin_b, strap_pin_a};
    strap_s2_q <= strap_s1_q;
    pin_s1_q   <= od_pin_in;
    pin_s2_q   <= pin_s1_q;
    // A STOP idles the link even though no further SCL edge follows
    idle_s1_q  <= state_q == ST_IDLE || state_q == ST_IGNORE || stop_tgl_q != stop_ack_q;
    standby    <= idle_s1_q;
    if (reset)
    begin
      wr_sync_q  <= 3'h0;
      acc_sync_q <= 3'h0;
    end
    else
    begin
      wr_sync_q  <= {wr_sync_q[1:0], wr_tgl_q};
      acc_sync_q <= {acc_sync_q[1:0], acc_tgl_q};
    end
    wdata_core_q <= wdata_q;
  end

  // Latch, flag and alert next values
  always_comb
  begin
    pp_d    = push_pull_outputs;
    od_d    = open_drain_io_ports;
    ref_d   = ref_q;
    flag_d  = change_flags | (pin_s2_q ^ ref_q);
    alert_d = alert_oe_n & ~|((pin_s2_q ^ ref_q) & open_drain_io_ports);
    if (acc_sync_q[2] != acc_sync_q[1])
    begin
      flag_d  = '0;
      ref_d   = pin_s2_q;
      alert_d = 1'b1;
    end
    if (wr_sync_q[2] != wr_sync_q[1])
    begin
      if (hi_grp_core)
        pp_d[`HI_OUT_MSB:`HI_OUT_LSB] = wdata_core_q;
      else
      begin
        pp_d[`LO_OUT_MSB_A:0] = wdata_core_q[`LO_PP_MSB_A:`LO_PP_LSB_A];
        pp_d[`LO_OUT_MSB_B:`LO_OUT_LSB_B] = wdata_core_q[`LO_PP_MSB_B:`LO_PP_LSB_B];
        od_d = wdata_core_q[`LO_OD_MSB:`LO_OD_LSB];
      end
    end
  end

  // Power-on defaults taken from straps at reset release
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      strap_taken_q       <= 1'b0;
      // Defaults track the straps during reset so the pins settle before release
      strap_q             <= '0;
      push_pull_outputs   <= {{8{strap_s2_q[1]}}, pair_of(strap_s2_q[1]),
                              pair_of(strap_s2_q[0])};
      open_drain_io_ports <= {pair_of(strap_s2_q[1]), pair_of(strap_s2_q[0])};
      od_pullup_en        <= {pair_of(strap_s2_q[1]), pair_of(strap_s2_q[0])};
      ref_q               <= pin_s2_q;
      change_flags        <= '0;
      alert_oe_n          <= 1'b1;
    end
    else if (!strap_taken_q)
    begin
      strap_taken_q       <= 1'b1;
      strap_q             <= strap_s2_q;
      od_pullup_en        <= {pair_of(strap_s2_q[1]), pair_of(strap_s2_q[0])};
      open_drain_io_ports <= {pair_of(strap_s2_q[1]), pair_of(strap_s2_q[0])};
      push_pull_outputs   <= {{8{strap_s2_q[1]}}, pair_of(strap_s2_q[1]),
                              pair_of(strap_s2_q[0])};
      ref_q               <= pin_s2_q;
      change_flags        <= '0;
      alert_oe_n          <= 1'b1;
    end
    else
    begin
      push_pull_outputs   <= pp_d;
      open_drain_io_ports <= od_d;
      ref_q               <= ref_d;
      change_flags        <= flag_d;
      alert_oe_n          <= alert_d;
    end
  end

endmodule : i2c_port_expander_core

// ### od_pin_model.sv
`timescale 1ns/100ps
module od_pin_model
  import port_expander_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic [3:0] open_drain_io_ports,
  input  wire logic [3:0] od_pullup_en,
  input  wire logic [3:0] ext_en,
  input  wire logic [3:0] ext_lvl,
  output logic [3:0]      od_pin_in
);
  logic flt_q = 1'b0;

  // Undriven pin without pullup wanders every cycle
  always @(posedge core_clk)
    flt_q <= ~flt_q;

  // Wired-AND: a low latch sinks, else a source or the pullup sets the pin
  assign od_pin_in = open_drain_io_ports & ((ext_en & ext_lvl)
                     | (~ext_en & (od_pullup_en | {4{flt_q}})));
endmodule : od_pin_model

// ### i2c_port_expander_chk.sv
`timescale 1ns/100ps
module i2c_port_expander_chk
  import port_expander_pkg::*;
#(
  parameter int PP_COUNT = 12,
  parameter int OD_COUNT = 4
)
(
  input wire logic                core_clk,
  input wire logic                reset,
  input wire logic                sda_oe_n,
  input wire logic                strap_pin_a,
  input wire logic                strap_pin_b,
  input wire logic [OD_COUNT-1:0] open_drain_io_ports,
  input wire logic [OD_COUNT-1:0] od_pullup_en,
  input wire logic [PP_COUNT-1:0] push_pull_outputs,
  input wire logic [OD_COUNT-1:0] change_flags,
  input wire logic                alert_oe_n,
  input wire logic                standby
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // Pair pattern implied by the straps
  logic [3:0] pair_map;
  assign pair_map = {{2{strap_pin_b}}, {2{strap_pin_a}}};

  a_flag_alert: assert property ($fell(alert_oe_n) |-> ##[0:3] (|change_flags))
    else $error("alert low with no flag");
  a_flag_clear: assert property (|($past(change_flags) & ~change_flags) |-> !standby)
    else $error("flag cleared while idle");
  a_flag_hold: assert property (standby |=> (change_flags & $past(change_flags)) == $past(change_flags))
    else $error("flag lost while idle");
  a_alert_hold: assert property (!alert_oe_n && standby |=> !alert_oe_n)
    else $error("alert released while idle");
  a_sda_busy: assert property (!sda_oe_n |-> !standby)
    else $error("standby while driving data line");
  a_pullup_map: assert property (!$past(reset) |-> od_pullup_en == pair_map)
    else $error("pullups differ from straps");
  a_defaults_load: assert property ($fell(reset) |=> open_drain_io_ports == pair_map
    && push_pull_outputs == {{10{strap_pin_b}}, {2{strap_pin_a}}}
    && change_flags == 4'h0 && alert_oe_n)
    else $error("power-up defaults wrong");
  a_latch_idle: assert property (standby && $past(standby, 8)
    |-> $stable({push_pull_outputs, open_drain_io_ports}))
    else $error("latch changed while idle");

  c_alert: cover property ($fell(alert_oe_n));
  c_clear: cover property ($rose(alert_oe_n));
  c_busy: cover property ($fell(standby));
endmodule : i2c_port_expander_chk

bind i2c_port_expander_core i2c_port_expander_chk #(.PP_COUNT(PP_COUNT), .OD_COUNT(OD_COUNT))
  i2c_port_expander_chk_i (.*);

// ### tb_i2c_port_expander_core.sv
`timescale 1ns/100ps
`include "port_expander_regs.svh"
module tb_i2c_port_expander_core
  import port_expander_pkg::*;
;
  localparam logic [6:0] lo_addr = {`LO_GROUP_PREFIX, 4'h0};
  localparam logic [6:0] hi_addr = {`HI_GROUP_PREFIX, 4'h0};
  logic        core_clk = 0, reset = 0, scl_clk = 1, sda_m = 1, bus_abort_n = 1;
  logic        strap_pin_a = 1, strap_pin_b = 1;
  logic [3:0]  ext_en = 0, ext_lvl = 0, od_pin_in, open_drain_io_ports;
  logic [3:0]  od_pullup_en, change_flags;
  logic [11:0] push_pull_outputs;
  logic        sda_in, sda_oe_n, sda_out, alert_oe_n, standby;
  logic [7:0]  rd;
  int          err_count = 0, num_checks = 0;

  // Core clock and the wired data line
  always #25 core_clk = ~core_clk;
  assign sda_in = sda_m & (sda_oe_n | sda_out);

  i2c_port_expander_core i2c_port_expander_core_i (.*);
  od_pin_model od_pin_model_i (.*);

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle();
    repeat (8) @(posedge core_clk);
    #5;
  endtask : settle

  // One link bit, sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    #16 scl_clk = 1;
    #16 r = sda_in;
    #16 scl_clk = 0;
    #16;
  endtask : bit_x

  task automatic byte_x(input logic [7:0] w, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_x(w[i], r[i]);
    bit_x(1'b1, a);
  endtask : byte_x

  task automatic frame_start();
    sda_m = 0;
    #16 scl_clk = 0;
    #16;
  endtask : frame_start

  task automatic frame_stop();
    sda_m = 0;
    #16 scl_clk = 1;
    #16 sda_m = 1;
    settle();
  endtask : frame_stop

  task automatic xfer(input logic [6:0] a, input logic rw, input logic [7:0] w);
    logic [7:0] x;
    logic       n;
    frame_start();
    byte_x({a, rw}, x, n);
    chk(12'(n), 12'h0);
    byte_x(w, rd, n);
    frame_stop();
  endtask : xfer

  task automatic por(input logic a, input logic b);
    reset = 1;
    strap_pin_a = a;
    strap_pin_b = b;
    scl_clk = 0;
    #32 scl_clk = 1;
    repeat (20) @(posedge core_clk);
    #5 reset = 0;
    settle();
    chk(push_pull_outputs, {{10{b}}, {2{a}}});
    chk(12'(open_drain_io_ports), 12'({{2{b}}, {2{a}}}));
    chk(12'(od_pullup_en), 12'({{2{b}}, {2{a}}}));
    chk(12'({change_flags, alert_oe_n, standby}), 12'h3);
  endtask : por

  task automatic print_verdict();
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  // Watchdog
  initial
  begin
    #100000;
    err_count++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    logic n;
    por(1'b0, 1'b1);
    por(1'b1, 1'b0);
    por(1'b1, 1'b1);
    xfer(lo_addr, 1'b0, 8'hbd);
    xfer(hi_addr, 1'b0, 8'h5a);
    chk(push_pull_outputs, 12'h5a9);
    chk(12'(open_drain_io_ports), 12'hf);
    // Short low glitch on port 2
    ext_en = 4'h4;
    settle();
    ext_en = 4'h0;
    settle();
    chk(12'({change_flags, alert_oe_n}), 12'h08);
    // Abort inside the address bits, no stop follows
    frame_start();
    bit_x(1'b1, n);
    bus_abort_n = 0;
    repeat (3) bit_x(1'b1, n);
    bus_abort_n = 1;
    // Let the released abort pass its synchroniser before the next START
    repeat (2) bit_x(1'b1, n);
    #16 scl_clk = 1;
    settle();
    chk(12'({alert_oe_n, standby}), 12'h1);
    chk(12'(change_flags), 12'h4);
    // Hold port 3 low, then read the pins
    ext_en = 4'h8;
    settle();
    chk(12'(change_flags), 12'hc);
    xfer(lo_addr, 1'b1, 8'hff);
    chk(12'(rd), 12'h9d);
    chk(12'({change_flags, alert_oe_n}), 12'h01);
    // Release port 3; a write clears again
    ext_en = 4'h0;
    settle();
    chk(12'(change_flags), 12'h8);
    xfer(hi_addr, 1'b0, 8'h00);
    chk(12'({change_flags, alert_oe_n}), 12'h01);
    chk(push_pull_outputs, 12'h009);
    por(1'b0, 1'b0);
    print_verdict();
  end
endmodule : tb_i2c_port_expander_core
